// ===== inc/dsc_pkg.sv
// Purpose: shared constants for the serial control line block
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes: offsets are byte addresses, one aligned word per register
package dsc_pkg;
	localparam int CLK_HZ = 20_000_000;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_MODEM = 8'h04;
	localparam logic [7:0] ADDR_DELAY = 8'h08;
	localparam logic [7:0] ADDR_BAUD = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_EVENT = 8'h14;
	// control register fields
	localparam int CTRL_SYNC = 0;
	localparam int CTRL_FLOW = 1;
	localparam int CTRL_RTSRESP = 2;
	localparam int CTRL_FORCECD = 3;
	localparam int CTRL_EXTCLK = 4;
	localparam int CTRL_DTRACT = 6;
	localparam int CTRL_RING = 8;
	// modem state register fields
	localparam int MDM_CMD = 0;
	localparam int MDM_OFFHOOK = 1;
	localparam int MDM_TEST = 2;
	localparam int MDM_TESTERR = 3;
	localparam int MDM_DSR = 4;
	localparam int MDM_READY = 5;
	// reset values
	localparam logic [15:0] CTRL_RST = 16'h0040;
	localparam logic [5:0] MODEM_RST = 6'h01;
	localparam logic [7:0] DELAY_RST = 8'h01;
	localparam logic [15:0] BAUD_RST = 16'h000A;
	// timing
	localparam int DELAY_UNIT_MS = 10;
	localparam int DELAY_UNIT_CYC = CLK_HZ / 1000 * DELAY_UNIT_MS;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	// reaction to terminal ready falling
	typedef enum logic [1:0] {
		DTR_IGNORE = 2'b00,
		DTR_COMMAND = 2'b01,
		DTR_HANGUP = 2'b10,
		DTR_RESET = 2'b11
	} dsc_dtr_t;
	// clear-to-send sequencing in synchronous modes
	typedef enum logic [1:0] {
		CS_ON = 2'b00,
		CS_WAIT_LINE = 2'b01,
		CS_WAIT_RTS = 2'b10,
		CS_DELAY = 2'b11
	} dsc_cts_t;
endpackage : dsc_pkg

// ===== src/dsc_clk_gen.sv
// Purpose: even duty clock generator for the synchronous data clocks
// Assumes: halfPeriod is the number of system cycles per half period
// Notes: output idles high while disabled; risePulse marks each rising edge
module dsc_clk_gen #(
	parameter int WIDTH = 16
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic enable,
	input wire logic [WIDTH-1:0] halfPeriod,
	output logic clkOut,
	output logic risePulse
);
	logic [WIDTH-1:0] cnt_r;
	logic [WIDTH-1:0] lastCnt;
	logic wrap;

	// a zero half period behaves as one cycle
	assign lastCnt = (halfPeriod == '0) ? '0 : halfPeriod - 1'b1;
	assign wrap = enable & (cnt_r >= lastCnt);

	// half period counter and output toggle
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			clkOut <= 1'b1;
			risePulse <= 1'b0;
		end else begin
			cnt_r <= (!enable || wrap) ? '0 : cnt_r + 1'b1;
			clkOut <= enable ? (clkOut ^ wrap) : 1'b1;
			risePulse <= wrap & ~clkOut;
		end
	end
endmodule : dsc_clk_gen

// ===== src/dsc_serial_lines.sv
// Purpose: modem side of the serial terminal interface control lines
// Assumes: modem state written by firmware over APB, line events on clk_sys
// Notes: terminal pins pass a two-flop synchroniser before use
// Behaviour
// - receive data carries line data or responses; only responses in command mode.
// - asynchronous mode keeps clear-to-send on unless hardware flow control chosen.
// - synchronous mode keeps clear-to-send on in the command state.
// - synchronous off-hook drops clear-to-send until set-ready, carrier and ready.
// - optionally clear-to-send follows an off-to-on transition of request-to-send.
// - carrier detect follows line carrier unless forced on.
// - test mode output is low in test mode, high otherwise.
// - ring indicator is low during each ring on segment.
// - terminal-ready falling enters disconnect with the configured reaction.
// - request-to-send is ignored in the command state.
// - asynchronous mode ignores request-to-send unless hardware flow control chosen.
// - synchronous on-line ignores request-to-send or raises clear-to-send after delay.
// - synchronous modes output a receive clock at data rate, even duty.
// - synchronous modes output a transmit clock at data rate, even duty.
// - auto-answer lamp is on while the answer ring count is non-zero.
// - test lamp flashes in test mode when an error is detected.
// - terminal-ready lamp follows terminal-ready, held on when it is ignored.
// - off-hook lamp shows the off-hook relay state.
module dsc_serial_lines
	import dsc_pkg::*;
#(
	parameter int DELAY_UNIT_CYCLES = DELAY_UNIT_CYC,
	parameter int BLINK_CYCLES = BLINK_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic txData,
	input wire logic terminalReadyN,
	input wire logic requestToSendN,
	input wire logic externalTxClock,
	output logic rxData,
	output logic ctsN,
	output logic dsrN,
	output logic carrierDetectN,
	output logic testModeN,
	output logic ringIndicatorN,
	output logic syncRxClock,
	output logic syncTxClock,
	output logic autoAnswerLampN,
	output logic testLampN,
	output logic terminalReadyLampN,
	output logic offHookLampN,
	input wire logic lineRxData,
	input wire logic respData,
	input wire logic carrierPresent,
	input wire logic ringOn,
	output logic termData,
	output logic txBitData,
	output logic txBitStrobe,
	output logic dtrDropPulse,
	output logic [1:0] dtrDropAction
);
	logic [15:0] ctrl_r;
	logic [5:0] modem_r;
	logic [7:0] delay_r;
	logic [15:0] baud_r;
	logic event_r;
	logic [3:0] syncA_r;
	logic [3:0] syncB_r;
	logic extPrev_r;
	logic dtrOnPrev_r;
	logic rtsOnPrev_r;
	logic offHookPrev_r;
	logic [31:0] tickCnt_r;
	logic [31:0] blinkCnt_r;
	logic blink_r;
	logic [7:0] delayCnt_r;
	dsc_cts_t ctsState_r;
	dsc_cts_t ctsState_nxt;
	logic ctsOn_nxt;
	logic rxClkInt;
	logic txClkInt;
	logic rxRiseInt;
	logic txRiseInt;

	// apb decode
	wire logic setupPhase = psel & ~penable;
	wire logic hitCtrl = (paddr == ADDR_CTRL);
	wire logic hitModem = (paddr == ADDR_MODEM);
	wire logic hitDelay = (paddr == ADDR_DELAY);
	wire logic hitBaud = (paddr == ADDR_BAUD);
	wire logic hitStatus = (paddr == ADDR_STATUS);
	wire logic hitEvent = (paddr == ADDR_EVENT);
	wire logic mapped = hitCtrl | hitModem | hitDelay | hitBaud | hitStatus | hitEvent;
	wire logic wrEn = psel & penable & pwrite & pready & mapped;

	// control fields
	wire logic syncMode = ctrl_r[CTRL_SYNC];
	wire logic flowCtl = ctrl_r[CTRL_FLOW];
	wire logic rtsResp = ctrl_r[CTRL_RTSRESP];
	wire logic forcedCd = ctrl_r[CTRL_FORCECD];
	wire logic extClkSel = ctrl_r[CTRL_EXTCLK];
	wire logic [1:0] dtrAction = ctrl_r[CTRL_DTRACT +: 2];
	wire logic [7:0] ringCount = ctrl_r[CTRL_RING +: 8];
	wire logic ignoreDtr = (dtrAction == DTR_IGNORE);
	wire logic cmdMode = modem_r[MDM_CMD];
	wire logic offHook = modem_r[MDM_OFFHOOK];
	wire logic testMode = modem_r[MDM_TEST];
	wire logic testErr = modem_r[MDM_TESTERR];
	wire logic dsrOn = modem_r[MDM_DSR];
	wire logic syncReady = modem_r[MDM_READY];

	// synchronised terminal pins and their edges
	wire logic txSync = syncB_r[0];
	wire logic dtrOn = ~syncB_r[1];
	wire logic rtsOn = ~syncB_r[2];
	wire logic extRise = syncB_r[3] & ~extPrev_r;
	wire logic dtrFall = dtrOnPrev_r & ~dtrOn;
	wire logic rtsRise = rtsOn & ~rtsOnPrev_r;
	wire logic offHookRise = offHook & ~offHookPrev_r;
	wire logic carrierOn = forcedCd | carrierPresent;
	wire logic lineOk = dsrOn & carrierOn & syncReady;
	wire logic unitTick = (tickCnt_r == 32'(DELAY_UNIT_CYCLES - 1));
	wire logic delayDone = (delayCnt_r == 8'h00);
	wire logic loadDelay = (ctsState_nxt == CS_DELAY) & (ctsState_r != CS_DELAY);
	wire logic eventClr = wrEn & hitEvent & pwdata[0];

	// read data select
	wire logic [31:0] statusWord = {25'h0, ctsState_r, carrierOn, ringOn, ~ctsN, rtsOn, dtrOn};
	wire logic [31:0] readMux = hitCtrl ? {16'h0, ctrl_r} :
		hitModem ? {26'h0, modem_r} :
		hitDelay ? {24'h0, delay_r} :
		hitBaud ? {16'h0, baud_r} :
		hitStatus ? statusWord :
		hitEvent ? {31'h0, event_r} : 32'h0;

	// apb slave answers in the cycle after setup
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= (setupPhase & ~pwrite) ? readMux : prdata;
			pready <= setupPhase;
			pslverr <= setupPhase & ~mapped;
		end
	end

	// software registers; the drop event set wins over its clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_r <= CTRL_RST;
			modem_r <= MODEM_RST;
			delay_r <= DELAY_RST;
			baud_r <= BAUD_RST;
			event_r <= 1'b0;
		end else begin
			if (wrEn & hitCtrl) ctrl_r <= pwdata[15:0];
			if (wrEn & hitModem) modem_r <= pwdata[5:0];
			if (wrEn & hitDelay) delay_r <= pwdata[7:0];
			if (wrEn & hitBaud) baud_r <= pwdata[15:0];
			event_r <= (dtrFall & ~ignoreDtr) | (event_r & ~eventClr);
		end
	end

	// two-flop synchroniser for the terminal pins
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			syncA_r <= 4'hF;
			syncB_r <= 4'hF;
		end else begin
			syncA_r <= {externalTxClock, requestToSendN, terminalReadyN, txData};
			syncB_r <= syncA_r;
		end
	end

	// previous values for edge detection
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			extPrev_r <= 1'b1;
			dtrOnPrev_r <= 1'b0;
			rtsOnPrev_r <= 1'b0;
			offHookPrev_r <= 1'b0;
		end else begin
			extPrev_r <= syncB_r[3];
			dtrOnPrev_r <= dtrOn;
			rtsOnPrev_r <= rtsOn;
			offHookPrev_r <= offHook;
		end
	end

	// delay unit tick and lamp blink dividers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tickCnt_r <= 32'h0;
			blinkCnt_r <= 32'h0;
			blink_r <= 1'b0;
		end else begin
			tickCnt_r <= (loadDelay | unitTick) ? 32'h0 : tickCnt_r + 32'h1;
			if (blinkCnt_r == 32'(BLINK_CYCLES - 1)) begin
				blinkCnt_r <= 32'h0;
				blink_r <= ~blink_r;
			end else begin
				blinkCnt_r <= blinkCnt_r + 32'h1;
			end
		end
	end

	// clear-to-send sequencing for synchronous modes
	always_comb begin
		ctsState_nxt = ctsState_r;
		if (!syncMode || cmdMode) begin
			ctsState_nxt = CS_ON;
		end else if (offHookRise) begin
			ctsState_nxt = CS_WAIT_LINE;
		end else begin
			case (ctsState_r)
				CS_ON: begin
					if (rtsResp && !rtsOn) ctsState_nxt = CS_WAIT_RTS;
				end
				CS_WAIT_LINE: begin
					if (lineOk) ctsState_nxt = rtsResp ? CS_WAIT_RTS : CS_ON;
				end
				CS_WAIT_RTS: begin
					if (!rtsResp) ctsState_nxt = CS_ON;
					else if (rtsRise) ctsState_nxt = CS_DELAY;
				end
				CS_DELAY: begin
					if (!rtsOn) ctsState_nxt = CS_WAIT_RTS;
					else if (delayDone) ctsState_nxt = CS_ON;
				end
				default: ctsState_nxt = CS_ON;
			endcase
		end
	end

	// asynchronous mode follows request-to-send only under hardware flow control
	assign ctsOn_nxt = syncMode ? (ctsState_nxt == CS_ON) :
		(cmdMode | ~flowCtl | rtsOn);

	// state register and delay counter
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctsState_r <= CS_ON;
			delayCnt_r <= 8'h00;
		end else begin
			ctsState_r <= ctsState_nxt;
			if (loadDelay) delayCnt_r <= delay_r;
			else if (unitTick && !delayDone) delayCnt_r <= delayCnt_r - 8'h01;
		end
	end

	// interchange circuit and lamp outputs
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctsN <= 1'b1;
			dsrN <= 1'b1;
			carrierDetectN <= 1'b1;
			testModeN <= 1'b1;
			ringIndicatorN <= 1'b1;
			autoAnswerLampN <= 1'b1;
			testLampN <= 1'b1;
			terminalReadyLampN <= 1'b1;
			offHookLampN <= 1'b1;
		end else begin
			ctsN <= ~ctsOn_nxt;
			dsrN <= ~dsrOn;
			carrierDetectN <= ~carrierOn;
			testModeN <= ~testMode;
			ringIndicatorN <= ~ringOn;
			autoAnswerLampN <= (ringCount == 8'h00);
			testLampN <= ~(testMode & testErr & blink_r);
			terminalReadyLampN <= ~(ignoreDtr | dtrOn);
			offHookLampN <= ~offHook;
		end
	end

	// data paths and disconnect request
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rxData <= 1'b1;
			termData <= 1'b1;
			txBitData <= 1'b1;
			txBitStrobe <= 1'b0;
			dtrDropPulse <= 1'b0;
			dtrDropAction <= DTR_IGNORE;
		end else begin
			rxData <= cmdMode ? respData : lineRxData;
			termData <= txSync;
			txBitStrobe <= syncMode & (extClkSel ? extRise : txRiseInt);
			if (syncMode & (extClkSel ? extRise : txRiseInt)) txBitData <= txSync;
			dtrDropPulse <= dtrFall & ~ignoreDtr;
			if (dtrFall) dtrDropAction <= dtrAction;
		end
	end

	// synchronous receive and transmit data clocks
	dsc_clk_gen #(.WIDTH(16)) rxClkGen (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.enable(syncMode),
		.halfPeriod(baud_r),
		.clkOut(rxClkInt),
		.risePulse(rxRiseInt)
	);
	dsc_clk_gen #(.WIDTH(16)) txClkGen (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.enable(syncMode),
		.halfPeriod(baud_r),
		.clkOut(txClkInt),
		.risePulse(txRiseInt)
	);
	assign syncRxClock = rxClkInt;
	assign syncTxClock = txClkInt;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	sequence extEdgeSel;
		syncMode && extClkSel && extRise;
	endsequence
	sequence rtsArmed;
		syncMode && !cmdMode && !offHookRise && ctsState_r == CS_WAIT_RTS && rtsResp;
	endsequence

	async_cts_on_a: assert property (!syncMode && !flowCtl |=> !ctsN)
		else $error("cts not on in asynchronous mode");
	cmd_cts_on_a: assert property (syncMode && cmdMode |=> !ctsN)
		else $error("cts not on in command state");
	offhook_cts_off_a: assert property (syncMode && !cmdMode && offHookRise |=> ctsN)
		else $error("cts not dropped on off-hook");
	wait_line_a: assert property (syncMode && !cmdMode && ctsState_r == CS_WAIT_LINE
		&& !lineOk |=> ctsN && ctsState_r == CS_WAIT_LINE)
		else $error("cts raised before line ready");
	rts_delay_a: assert property (rtsArmed ##0 rtsRise |=> ctsState_r == CS_DELAY ##0 ctsN)
		else $error("rts edge did not start delay");
	carrier_follow_a: assert property (!forcedCd |=> carrierDetectN == !$past(carrierPresent))
		else $error("carrier detect wrong");
	test_mode_a: assert property (1'b1 |=> testModeN == !$past(testMode))
		else $error("test mode output wrong");
	ring_follow_a: assert property (ringOn |=> !ringIndicatorN)
		else $error("ring indicator not on");
	dtr_drop_a: assert property (dtrFall && !ignoreDtr |=> dtrDropPulse && event_r
		##1 !dtrDropPulse)
		else $error("terminal ready drop not reported");
	async_rts_ign_a: assert property (!syncMode && !flowCtl && $changed(rtsOn)
		|=> $stable(ctsN))
		else $error("cts moved with rts while ignored");
	aa_lamp_a: assert property (ringCount != 8'h00 |=> !autoAnswerLampN)
		else $error("auto answer lamp off");
	dtr_lamp_a: assert property (ignoreDtr |=> !terminalReadyLampN)
		else $error("terminal ready lamp not held on");
	rx_cmd_a: assert property (cmdMode |=> rxData == $past(respData))
		else $error("receive data not response in command mode");
	ext_sample_a: assert property (extEdgeSel |=> txBitStrobe && txBitData == $past(txSync))
		else $error("external clock edge not sampled");
endmodule : dsc_serial_lines

// ===== verification/dsc_term_model.sv
// Purpose: behavioural terminal on the far side of the serial control lines
// Assumes: the bench steers ready, request and data through plain level inputs
// Notes: the external transmit clock runs only while clkRun is high, else stands still
module dsc_term_model (
	input wire logic dtrOn,
	input wire logic rtsOn,
	input wire logic clkRun,
	input wire logic txBit,
	output logic txData,
	output logic terminalReadyN,
	output logic requestToSendN,
	output logic externalTxClock,
	output logic sampledBit
);
	timeunit 1ns;
	timeprecision 1ns;
	logic heldBit = 1'b1;
	// ready and request are active low levels from the terminal
	assign terminalReadyN = ~dtrOn;
	assign requestToSendN = ~rtsOn;
	// one data line carries both payload and command text
	assign txData = clkRun ? heldBit : txBit;
	// 400 ns transmit clock, phase unrelated to the system clock
	initial begin
		externalTxClock = 1'b1;
		#37;
		forever begin
			#200;
			if (clkRun) begin
				externalTxClock = ~externalTxClock;
			end
		end
	end
	// data changes on the falling edge so it is stable at the rising one
	always @(negedge externalTxClock) begin
		heldBit <= txBit;
	end
	// remember what the modem should take at each rising edge
	always @(posedge externalTxClock) begin
		sampledBit <= heldBit;
	end
endmodule : dsc_term_model

// ===== verification/testbench.sv
// Purpose: self-checking bench for the serial control line block
// Assumes: short delay and blink counts, registers reached over APB
// Notes: random traffic from a fixed seed mixed with corner cases
module testbench
	import dsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic txData, terminalReadyN, requestToSendN, externalTxClock, rxData, ctsN, dsrN;
	logic carrierDetectN, testModeN, ringIndicatorN, syncRxClock, syncTxClock;
	logic autoAnswerLampN, testLampN, terminalReadyLampN, offHookLampN;
	logic lineRxData, respData, carrierPresent, ringOn, termData, txBitData, txBitStrobe;
	logic dtrDropPulse, dtrOn, rtsOn, clkRun, txBit, sampledBit, e;
	logic [1:0] dtrDropAction;
	int seed = 32'h8d77;
	int errTotal = 0;
	int nTests = 0;
	int cycles = 0;
	int i, m, n, b;
	dsc_serial_lines #(.DELAY_UNIT_CYCLES(20), .BLINK_CYCLES(8)) dsc_serial_lines_i (
		.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .txData(txData),
		.terminalReadyN(terminalReadyN), .requestToSendN(requestToSendN),
		.externalTxClock(externalTxClock), .rxData(rxData), .ctsN(ctsN),
		.dsrN(dsrN), .carrierDetectN(carrierDetectN), .testModeN(testModeN),
		.ringIndicatorN(ringIndicatorN), .syncRxClock(syncRxClock),
		.syncTxClock(syncTxClock), .autoAnswerLampN(autoAnswerLampN),
		.testLampN(testLampN), .terminalReadyLampN(terminalReadyLampN),
		.offHookLampN(offHookLampN), .lineRxData(lineRxData),
		.respData(respData), .carrierPresent(carrierPresent), .ringOn(ringOn),
		.termData(termData), .txBitData(txBitData), .txBitStrobe(txBitStrobe),
		.dtrDropPulse(dtrDropPulse), .dtrDropAction(dtrDropAction));
	dsc_term_model dsc_term_model_i (.dtrOn(dtrOn), .rtsOn(rtsOn), .clkRun(clkRun),
		.txBit(txBit), .txData(txData), .terminalReadyN(terminalReadyN),
		.requestToSendN(requestToSendN), .externalTxClock(externalTxClock),
		.sampledBit(sampledBit));
	// 20 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// expected receive data: responses in command mode, line data otherwise
	function automatic logic expRx(input logic cmd, input logic resp, input logic line);
		return cmd ? resp : line;
	endfunction : expRx
	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask : cyc
	// one APB transfer, held until pready is sampled high
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// main sequence
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{lineRxData, respData, carrierPresent, ringOn, dtrOn, rtsOn, clkRun, txBit} = '0;
		cyc(3);
		nrst <= 1'b1;
		cyc(1);
		// reset values and an unmapped word
		apb(0, ADDR_CTRL, 0); chk("ctrl", q, {16'h0, CTRL_RST});
		apb(0, ADDR_MODEM, 0); chk("modem", q, {26'h0, MODEM_RST});
		apb(0, ADDR_DELAY, 0); chk("delay", q, {24'h0, DELAY_RST});
		apb(0, ADDR_BAUD, 0); chk("baud", q, {16'h0, BAUD_RST});
		apb(0, 8'h18, 0); chk("unmapped", {q[30:0], e}, 32'h1);
		// random line events, command mode then on-line
		for (m = 0; m < 2; m++) begin
			wr(ADDR_MODEM, (m == 0) ? 32'h1 : 32'h0);
			for (i = 0; i < 16; i++) begin
				{lineRxData, respData, carrierPresent, ringOn, txBit} <= 5'($random(seed));
				cyc(4);
				chk("rx", rxData, expRx(m == 0, respData, lineRxData));
				chk("cd", carrierDetectN, !carrierPresent);
				chk("ri", ringIndicatorN, !ringOn);
				chk("dsrOff", dsrN, 1);
				chk("term", termData, txBit);
			end
		end
		carrierPresent <= 1'b0;
		wr(ADDR_CTRL, 32'h48); cyc(2); chk("cdForced", carrierDetectN, 0);
		// test mode, lamps
		wr(ADDR_MODEM, 32'h16); cyc(2);
		chk("tm", testModeN, 0);
		chk("ohLamp", offHookLampN, 0);
		chk("dsr", dsrN, 0);
		chk("tLamp", testLampN, 1);
		wr(ADDR_MODEM, 32'h0E);
		n = 0;
		for (i = 0; i < 40; i++) begin
			cyc(1);
			n += (testLampN === 1'b0);
		end
		chk("flash", (n > 8 && n < 32), 1);
		wr(ADDR_MODEM, 32'h0); cyc(2);
		chk("tmOff", {testModeN, offHookLampN, testLampN, dsrN}, 4'hF);
		wr(ADDR_CTRL, 32'h140); cyc(2); chk("aaOn", autoAnswerLampN, 0);
		wr(ADDR_CTRL, 32'h40); cyc(2); chk("aaOff", autoAnswerLampN, 1);
		// terminal-ready drop under every configured reaction
		for (m = 0; m < 4; m++) begin
			wr(ADDR_CTRL, m << 6);
			dtrOn <= 1'b1; cyc(6);
			chk("dtrLampOn", terminalReadyLampN, 0);
			dtrOn <= 1'b0;
			n = 0;
			while (dtrDropPulse !== 1'b1 && n < 10) begin cyc(1); n++; end
			chk("drop", n < 10, m != 0);
			if (m != 0) chk("act", dtrDropAction, m);
			cyc(3);
			chk("dtrLamp", terminalReadyLampN, m != 0);
			if (m < 3) begin
				apb(0, ADDR_EVENT, 0); chk("evt", q, m != 0);
				wr(ADDR_EVENT, 32'h1); apb(0, ADDR_EVENT, 0); chk("evtClr", q, 0);
			end
		end
		// asynchronous: request-to-send has no effect on clear-to-send
		wr(ADDR_CTRL, 32'h40); wr(ADDR_MODEM, 32'h0);
		for (i = 0; i < 8; i++) begin
			rtsOn <= 1'($random(seed)); cyc(5);
			chk("ctsAsync", ctsN, 0);
		end
		// asynchronous with hardware flow control: clear-to-send follows request
		wr(ADDR_CTRL, 32'h42);
		for (i = 0; i < 4; i++) begin
			rtsOn <= 1'($random(seed)); cyc(5);
			chk("ctsFlow", ctsN, !rtsOn);
		end
		// synchronous: command state, then off-hook sequencing
		wr(ADDR_CTRL, 32'h41); wr(ADDR_MODEM, 32'h1);
		for (i = 0; i < 4; i++) begin
			rtsOn <= ~rtsOn; cyc(5);
			chk("ctsCmd", ctsN, 0);
		end
		wr(ADDR_MODEM, 32'h2); cyc(1); chk("ctsHook", ctsN, 1);
		wr(ADDR_MODEM, 32'h32); cyc(4); chk("ctsNoCd", ctsN, 1);
		carrierPresent <= 1'b1; cyc(4); chk("ctsUp", ctsN, 0);
		apb(0, ADDR_STATUS, 0);
		chk("status", q, {25'h0, 2'b00, 1'b1, ringOn, 1'b1, rtsOn, dtrOn});
		// rts response with a programmed delay of three units
		rtsOn <= 1'b0;
		wr(ADDR_DELAY, 32'h3); wr(ADDR_CTRL, 32'h45);
		wr(ADDR_MODEM, 32'h30); wr(ADDR_MODEM, 32'h32); cyc(4);
		chk("ctsWait", ctsN, 1);
		rtsOn <= 1'b1;
		n = 0;
		while (ctsN !== 1'b0 && n < 100) begin cyc(1); n++; end
		chk("ctsDelay", (n >= 60 && n <= 66), 1);
		// synchronous data clocks with a random half period
		b = 2 + ({$random(seed)} % 6);
		wr(ADDR_BAUD, b);
		while (syncRxClock !== 1'b0) cyc(1);
		while (syncRxClock !== 1'b1) cyc(1);
		n = 0;
		while (syncRxClock === 1'b1 && n < 20) begin cyc(1); n++; end
		chk("rxHigh", n, b);
		chk("txLock", syncTxClock, syncRxClock);
		n = 0;
		while (syncRxClock === 1'b0 && n < 20) begin cyc(1); n++; end
		chk("rxLow", n, b);
		chk("txLock2", syncTxClock, syncRxClock);
		// external transmit clock sampling
		wr(ADDR_CTRL, 32'h51);
		// let a strobe launched under the internal clock pass first
		cyc(2);
		clkRun <= 1'b1;
		for (i = 0; i < 12; i++) begin
			n = 0;
			while (txBitStrobe !== 1'b1 && n < 40) begin cyc(1); n++; end
			chk("xBit", txBitData, sampledBit);
			txBit <= 1'($random(seed));
			cyc(1);
		end
		clkRun <= 1'b0;
		wr(ADDR_CTRL, 32'h40); cyc(3);
		chk("clkIdle", {syncRxClock, syncTxClock}, 2'b11);
		report_and_stop();
	end
endmodule : testbench
